// *** design/fmcs_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fmcs_defines.svh"

//
// Contract
// (RULE1) Three max duty registers, one per PWM output, reset to full scale.
// (RULE2) With lock set, writes to the max duty registers are ignored.
// (RULE3) Host reads extended first; extended and MSB readings then freeze.
// (RULE4) Two's complement format: diode fault reads as the -128 code.
// (RULE5) Offset-64 format: diode fault reads as all zeros.
// (RULE6) Monitor start high: monitoring runs, PWM follows programmed limits.
// (RULE7) Monitor start low: default limits used, programmed limits kept.
// (RULE8) Monitor start stays writable after lock.
// (RULE9) Lock bit is write-once; locks all lockable bits until power cycle.
// (RULE10) Ready bit goes high once power-up has finished.
// (RULE11) Full speed bit drives fans at current duty; resets 0, never locked.
// (RULE12) Lockable read-write VRM current flag bit.
// (RULE13) Spin-up disable: ignore two-pulse end, hold PWM high whole timeout.
// (RULE14) Lockable bus timeout bit; 1 enables the timeout feature.
// (RULE15) Core and supply voltage flags set at status bits 1 and 2.
// (RULE16) Remote1, local, remote2 temperature flags at status bits 4, 5, 6.
// (RULE17) Flags latch; a status read clears only those whose cause is gone.
// (RULE18) Status bit 7 is the OR of all second status register flags.
// (RULE19) Monitoring disabled forces all PWM outputs to full duty.
// (RULE20) Duty codes are linear, 0x00 zero to 0xFF full.
// (RULE21) Reserved config bit 7, status bits 0 and 3 read zero.
// (RULE22) Automatic PWM never exceeds its max duty register.
module fmcs_regs (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire fmcs_pkg::fmcs_req_s req,
  output var  logic [7:0]          rdata,
  output var  logic                rvalid,
  input  wire logic                powerup_done,
  input  wire fmcs_pkg::fmcs_lim_s lim_fault,
  input  wire logic [7:0]          status2,
  input  wire fmcs_pkg::fmcs_read_s live,
  input  wire logic [2:0]          diode_fault,
  input  wire logic                temp_offset64,
  input  wire fmcs_pkg::fmcs_duty3_t auto_duty,
  input  wire fmcs_pkg::fmcs_duty3_t cur_duty,
  input  wire logic [2:0]          spin_timer_run,
  input  wire logic [2:0]          spin_two_tach,
  output var  fmcs_pkg::fmcs_duty3_t pwm_duty,
  output var  logic                monitor_en,
  output var  logic                default_limits,
  output var  logic                bus_timeout_en,
  output var  logic                vrm_current
);

  function automatic logic [7:0] duty_clamp(input logic [7:0] want,
                                            input logic [7:0] limit);
    duty_clamp = (want > limit) ? limit : want;
  endfunction

  function automatic logic [7:0] temp_code(input logic [7:0] raw,
                                           input logic       fault,
                                           input logic       of64);
    if (!fault) begin
      temp_code = raw;
    end else if (of64) begin
      temp_code = `FMCS_DIODE_OF64; // RULE5
    end else begin
      temp_code = `FMCS_DIODE_TWOS; // RULE4
    end
  endfunction

  fmcs_pkg::fmcs_duty3_t max_duty;
  fmcs_pkg::fmcs_duty3_t next_max_duty;
  logic                  monitor_start;
  logic                  next_monitor_start;
  logic                  cfg_lock;
  logic                  next_cfg_lock;
  logic                  ready;
  logic                  next_ready;
  logic                  fan_full_speed;
  logic                  next_fan_full_speed;
  logic                  vrm_current_flag;
  logic                  next_vrm_current_flag;
  logic                  spinup_disable;
  logic                  next_spinup_disable;
  logic                  bus_timeout_control;
  logic                  next_bus_timeout_control;
  logic [7:0]            limit_status;
  logic [7:0]            next_limit_status;
  logic                  second_status_summary;
  logic                  next_second_status_summary;
  fmcs_pkg::fmcs_read_s  snap;
  fmcs_pkg::fmcs_read_s  next_snap;
  fmcs_pkg::fmcs_read_s  live_fix;
  logic [4:0]            pending;
  logic [4:0]            next_pending;
  logic [7:0]            next_rdata;
  logic                  next_rvalid;
  fmcs_pkg::fmcs_duty3_t next_pwm_duty;
  logic                  wr_cfg;
  logic                  rd_stat;
  logic                  rd_ext;
  logic [7:0]            cause;
  logic [7:0]            main_configuration;

  assign wr_cfg  = req.wr && (req.addr == `FMCS_A_CFG);
  assign rd_stat = req.rd && (req.addr == `FMCS_A_STAT);
  assign rd_ext  = req.rd && ((req.addr == `FMCS_A_EXT1) ||
                              (req.addr == `FMCS_A_EXT2));

  // Assembled configuration view; bit 7 reads zero
  always_comb begin
    main_configuration                 = 8'h00; // RULE21
    main_configuration[`FMCS_B_START]  = monitor_start;
    main_configuration[`FMCS_B_LOCK]   = cfg_lock;
    main_configuration[`FMCS_B_RDY]    = ready;
    main_configuration[`FMCS_B_FAN_FULL_SPEED]   = fan_full_speed;
    main_configuration[`FMCS_B_VRM]    = vrm_current_flag;
    main_configuration[`FMCS_B_SPDIS]  = spinup_disable;
    main_configuration[`FMCS_B_TMO]    = bus_timeout_control;
  end

  // Configuration and max duty registers
  always_comb begin
    next_max_duty            = max_duty;
    next_monitor_start       = monitor_start;
    next_cfg_lock            = cfg_lock;
    next_fan_full_speed      = fan_full_speed;
    next_vrm_current_flag    = vrm_current_flag;
    next_spinup_disable      = spinup_disable;
    next_bus_timeout_control = bus_timeout_control;
    next_ready               = ready | powerup_done; // RULE10
    if (req.wr && !cfg_lock) begin // RULE2
      if (req.addr == `FMCS_A_MAX1) begin
        next_max_duty[0] = req.wdata; // RULE1
      end
      if (req.addr == `FMCS_A_MAX2) begin
        next_max_duty[1] = req.wdata; // RULE1
      end
      if (req.addr == `FMCS_A_MAX3) begin
        next_max_duty[2] = req.wdata; // RULE1
      end
    end
    if (wr_cfg) begin
      next_monitor_start  = req.wdata[`FMCS_B_START]; // RULE8
      next_fan_full_speed = req.wdata[`FMCS_B_FAN_FULL_SPEED]; // RULE11
      next_spinup_disable = req.wdata[`FMCS_B_SPDIS];
      if (!cfg_lock) begin // RULE9
        next_cfg_lock            = req.wdata[`FMCS_B_LOCK];
        next_vrm_current_flag    = req.wdata[`FMCS_B_VRM]; // RULE12
        next_bus_timeout_control = req.wdata[`FMCS_B_TMO]; // RULE14
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      max_duty            <= {3{`FMCS_RST_MAX}}; // RULE1
      monitor_start       <= 1'(`FMCS_RST_CFG >> `FMCS_B_START);
      cfg_lock            <= 1'b0;
      ready               <= 1'b0;
      fan_full_speed      <= 1'b0; // RULE11
      vrm_current_flag    <= 1'b0;
      spinup_disable      <= 1'b0;
      bus_timeout_control <= 1'b0;
    end else if (clk_en) begin
      max_duty            <= next_max_duty;
      monitor_start       <= next_monitor_start;
      cfg_lock            <= next_cfg_lock;
      ready               <= next_ready;
      fan_full_speed      <= next_fan_full_speed;
      vrm_current_flag    <= next_vrm_current_flag;
      spinup_disable      <= next_spinup_disable;
      bus_timeout_control <= next_bus_timeout_control;
    end
  end

  // Sticky limit flags; a new cause wins over a read clear
  always_comb begin
    cause                 = 8'h00; // RULE21
    cause[`FMCS_B_CORE]   = lim_fault.vcore; // RULE15
    cause[`FMCS_B_SUP]    = lim_fault.vsupply; // RULE15
    cause[`FMCS_B_R1]     = lim_fault.remote1; // RULE16
    cause[`FMCS_B_LOCT]   = lim_fault.local_t; // RULE16
    cause[`FMCS_B_R2]     = lim_fault.remote2; // RULE16
    next_limit_status     = cause | (limit_status & {8{!rd_stat}}); // RULE17
    next_second_status_summary = |status2; // RULE18
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      limit_status          <= `FMCS_RST_STAT;
      second_status_summary <= 1'b0;
    end else if (clk_en) begin
      limit_status          <= next_limit_status;
      second_status_summary <= next_second_status_summary;
    end
  end

  // Reading snapshot with diode fault codes and read freeze
  always_comb begin
    live_fix         = live;
    live_fix.remote1 = temp_code(live.remote1, diode_fault[0],
                                 temp_offset64);
    live_fix.local_t = temp_code(live.local_t, diode_fault[1],
                                 temp_offset64);
    live_fix.remote2 = temp_code(live.remote2, diode_fault[2],
                                 temp_offset64);
    next_pending = pending;
    if (req.rd) begin
      case (req.addr)
        `FMCS_A_VCORE: next_pending[0] = 1'b0; // RULE3
        `FMCS_A_VSUP:  next_pending[1] = 1'b0; // RULE3
        `FMCS_A_RT1:   next_pending[2] = 1'b0; // RULE3
        `FMCS_A_LOC:   next_pending[3] = 1'b0; // RULE3
        `FMCS_A_RT2:   next_pending[4] = 1'b0; // RULE3
        default:       next_pending = pending;
      endcase
    end
    if (rd_ext) begin
      next_pending = 5'h1F; // RULE3
    end
    next_snap = ((|pending) || rd_ext) ? snap : live_fix; // RULE3
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      snap         <= '0;
      snap.remote1 <= `FMCS_RST_TRD;
      snap.local_t <= `FMCS_RST_TRD;
      snap.remote2 <= `FMCS_RST_TRD;
      snap.vcore   <= `FMCS_RST_VRD;
      snap.vsupply <= `FMCS_RST_VRD;
      pending      <= 5'h00;
    end else if (clk_en) begin
      snap         <= next_snap;
      pending      <= next_pending;
    end
  end

  // Read data, one cycle after the read strobe
  always_comb begin
    next_rvalid = req.rd;
    next_rdata  = rdata;
    if (req.rd) begin
      case (req.addr)
        `FMCS_A_MAX1:  next_rdata = max_duty[0];
        `FMCS_A_MAX2:  next_rdata = max_duty[1];
        `FMCS_A_MAX3:  next_rdata = max_duty[2];
        `FMCS_A_CFG:   next_rdata = main_configuration;
        `FMCS_A_STAT:  next_rdata = {second_status_summary,
                                     limit_status[6:0]}; // RULE18
        `FMCS_A_VCORE: next_rdata = snap.vcore;
        `FMCS_A_VSUP:  next_rdata = snap.vsupply;
        `FMCS_A_RT1:   next_rdata = snap.remote1;
        `FMCS_A_LOC:   next_rdata = snap.local_t;
        `FMCS_A_RT2:   next_rdata = snap.remote2;
        `FMCS_A_EXT1:  next_rdata = snap.ext1;
        `FMCS_A_EXT2:  next_rdata = snap.ext2;
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // PWM duty selection per output
  always_comb begin
    next_pwm_duty = pwm_duty;
    for (int i = 0; i < 3; i++) begin
      if (!monitor_start) begin
        next_pwm_duty[i] = `FMCS_FULL_DUTY; // RULE19
      end else if (spin_timer_run[i] &&
                   (spinup_disable || !spin_two_tach[i])) begin
        next_pwm_duty[i] = `FMCS_FULL_DUTY; // RULE13
      end else if (fan_full_speed) begin
        next_pwm_duty[i] = cur_duty[i]; // RULE11
      end else begin
        next_pwm_duty[i] = duty_clamp(auto_duty[i], max_duty[i]); // RULE22
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata          <= 8'h00;
      rvalid         <= 1'b0;
      pwm_duty       <= {3{`FMCS_FULL_DUTY}}; // RULE20
      monitor_en     <= 1'b0;
      default_limits <= 1'b1;
      bus_timeout_en <= 1'b0;
      vrm_current    <= 1'b0;
    end else if (clk_en) begin
      rdata          <= next_rdata;
      rvalid         <= next_rvalid;
      pwm_duty       <= next_pwm_duty;
      monitor_en     <= next_monitor_start; // RULE6
      default_limits <= !next_monitor_start; // RULE7
      bus_timeout_en <= next_bus_timeout_control; // RULE14
      vrm_current    <= next_vrm_current_flag;
    end
  end

endmodule
`default_nettype wire

// *** design/fmcs_defines.svh ***
`ifndef FMCS_DEFINES_SVH
`define FMCS_DEFINES_SVH
`define FMCS_A_MAX1     8'h38
`define FMCS_A_MAX2     8'h39
`define FMCS_A_MAX3     8'h3A
`define FMCS_A_CFG      8'h40
`define FMCS_A_STAT     8'h41
`define FMCS_A_VCORE    8'h21
`define FMCS_A_VSUP     8'h22
`define FMCS_A_RT1      8'h25
`define FMCS_A_LOC      8'h26
`define FMCS_A_RT2      8'h27
`define FMCS_A_EXT1     8'h76
`define FMCS_A_EXT2     8'h77
`define FMCS_B_START    0
`define FMCS_B_LOCK     1
`define FMCS_B_RDY      2
`define FMCS_B_FAN_FULL_SPEED     3
`define FMCS_B_VRM      4
`define FMCS_B_SPDIS    5
`define FMCS_B_TMO      6
`define FMCS_B_CORE     1
`define FMCS_B_SUP      2
`define FMCS_B_R1       4
`define FMCS_B_LOCT     5
`define FMCS_B_R2       6
`define FMCS_B_SUM      7
`define FMCS_RST_MAX    8'hFF
`define FMCS_RST_CFG    8'h04
`define FMCS_RST_STAT   8'h00
`define FMCS_RST_VRD    8'h00
`define FMCS_RST_TRD    8'h80
`define FMCS_FULL_DUTY  8'hFF
`define FMCS_DIODE_TWOS 8'h80
`define FMCS_DIODE_OF64 8'h00
`endif

// *** design/fmcs_pkg.sv ***
package fmcs_pkg;
  typedef logic [2:0][7:0] fmcs_duty3_t;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } fmcs_req_s;
  typedef struct packed {
    logic vcore;
    logic vsupply;
    logic remote1;
    logic local_t;
    logic remote2;
  } fmcs_lim_s;
  typedef struct packed {
    logic [7:0] vcore;
    logic [7:0] vsupply;
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
    logic [7:0] ext1;
    logic [7:0] ext2;
  } fmcs_read_s;
endpackage

// *** bench/fmcs_regs_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module fmcs_regs_checker (
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire logic                  clk_en,
  input wire fmcs_pkg::fmcs_req_s   req,
  input wire logic [7:0]            rdata,
  input wire logic                  rvalid,
  input wire logic [7:0]            status2,
  input wire logic [2:0]            spin_timer_run,
  input wire logic [2:0]            spin_two_tach,
  input wire fmcs_pkg::fmcs_duty3_t pwm_duty,
  input wire logic                  monitor_en,
  input wire logic                  default_limits,
  input wire logic                  bus_timeout_en,
  input wire logic                  vrm_current
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_stop_full_duty: assert property (clk_en && !monitor_en |=>
    pwm_duty == {3{8'hFF}}) else $error("pwm not full while stopped");
  a_limits_default: assert property (default_limits != monitor_en)
    else $error("default limits not inverse of start");
  a_start_writable: assert property (clk_en && req.wr &&
    req.addr == 8'h40 |=> monitor_en == $past(req.wdata[0]))
    else $error("start bit write lost");
  a_spin_hold: assert property (clk_en && spin_timer_run[2] &&
    !spin_two_tach[2] |=> pwm_duty[2] == 8'hFF)
    else $error("spin-up not at full duty");
  a_cfg_reserved: assert property (clk_en && req.rd &&
    req.addr == 8'h40 |=> rvalid && !rdata[7])
    else $error("config reserved bit set");
  a_stat_reserved: assert property (clk_en && req.rd &&
    req.addr == 8'h41 |=> rvalid && !rdata[0] && !rdata[3])
    else $error("status reserved bits set");
  a_summary_or: assert property (clk_en && req.rd &&
    req.addr == 8'h41 && $past(rst_b) && $past(clk_en) |=>
    rdata[7] == |$past(status2, 2)) else $error("summary bit wrong");
  a_lockable_cause: assert property ($past(rst_b) &&
    $changed({vrm_current, bus_timeout_en}) |->
    $past(clk_en && req.wr && req.addr == 8'h40))
    else $error("lockable bit moved without write");
endmodule
bind fmcs_regs fmcs_regs_checker i_fmcs_regs_checker (
  .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .rdata(rdata),
  .rvalid(rvalid), .status2(status2), .spin_timer_run(spin_timer_run),
  .spin_two_tach(spin_two_tach), .pwm_duty(pwm_duty),
  .monitor_en(monitor_en), .default_limits(default_limits),
  .bus_timeout_en(bus_timeout_en), .vrm_current(vrm_current));
`default_nettype wire

// *** bench/fmcs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fmcs_host_model (
  input  wire logic                mclk,
  input  wire logic                rvalid,
  input  wire logic [7:0]          rdata,
  output var  fmcs_pkg::fmcs_req_s req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    @(posedge mclk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    ok = 1'b0;
    d = 'x;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge mclk);
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** bench/tb_fan_monitor_config_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_fan_monitor_config_status_regs;
  logic                  mclk, rst_b, clk_en, rvalid, powerup_done;
  logic                  temp_offset64, monitor_en, default_limits;
  logic                  bus_timeout_en, vrm_current;
  logic [7:0]            rdata, status2;
  logic [2:0]            diode_fault, spin_timer_run, spin_two_tach;
  fmcs_pkg::fmcs_req_s   req;
  fmcs_pkg::fmcs_lim_s   lim_fault;
  fmcs_pkg::fmcs_read_s  live;
  fmcs_pkg::fmcs_duty3_t auto_duty, cur_duty, pwm_duty;
  int                    err_count = 0;
  int                    cmp_count = 0;
  int                    i;
  fmcs_regs i_fmcs_regs (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
    .req(req), .rdata(rdata), .rvalid(rvalid), .powerup_done(powerup_done),
    .lim_fault(lim_fault), .status2(status2), .live(live),
    .diode_fault(diode_fault), .temp_offset64(temp_offset64),
    .auto_duty(auto_duty), .cur_duty(cur_duty),
    .spin_timer_run(spin_timer_run), .spin_two_tach(spin_two_tach),
    .pwm_duty(pwm_duty), .monitor_en(monitor_en),
    .default_limits(default_limits), .bus_timeout_en(bus_timeout_en),
    .vrm_current(vrm_current));
  fmcs_host_model i_fmcs_host_model (.mclk(mclk), .rvalid(rvalid),
    .rdata(rdata), .req(req));
  always #10 mclk = ~mclk;
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_fmcs_host_model.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t no read response", $time);
      wrap_up();
    end else
      chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_fmcs_host_model.wr(a, d);
  endtask
  task automatic pchk(input fmcs_pkg::fmcs_duty3_t exp);
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 3; k++) chk(pwm_duty[k], exp[k]);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("MISMATCH %0t run timed out", $time);
    wrap_up();
  end
  initial begin
    mclk = 0; rst_b = 0; clk_en = 1; powerup_done = 0; lim_fault = '0;
    status2 = '0; diode_fault = '0; temp_offset64 = 0; auto_duty = '0;
    cur_duty = '0; spin_timer_run = '0; spin_two_tach = '0;
    live = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    pchk({3{8'hFF}});
    for (i = 0; i < 3; i++) rchk(8'h38 + 8'(i), 8'hFF);
    rchk(8'h40, 8'h00);
    @(posedge mclk) powerup_done <= 1'b1;
    rchk(8'h40, 8'h04);
    rchk(8'h50, 8'h00);
    @(posedge mclk) clk_en <= 1'b0;
    wr(8'h39, 8'h00);
    clk_en <= 1'b1;
    rchk(8'h39, 8'hFF);
    wr(8'h38, 8'h40);
    wr(8'h40, 8'hF1);
    rchk(8'h38, 8'h40);
    rchk(8'h40, 8'h75);
    chk({6'h00, bus_timeout_en, vrm_current}, 8'h03);
    @(posedge mclk) auto_duty <= '{8'h80, 8'h20, 8'h80};
    spin_timer_run <= 3'b100;
    pchk('{8'hFF, 8'h20, 8'h40});
    @(posedge mclk) spin_two_tach <= 3'b100;
    pchk('{8'hFF, 8'h20, 8'h40});
    wr(8'h40, 8'hD1);
    pchk('{8'h80, 8'h20, 8'h40});
    @(posedge mclk) cur_duty <= '{8'h33, 8'h22, 8'h11};
    wr(8'h40, 8'hD9);
    pchk('{8'h33, 8'h22, 8'h11});
    wr(8'h40, 8'h02);
    pchk({3{8'hFF}});
    rchk(8'h40, 8'h06);
    wr(8'h40, 8'hD9);
    rchk(8'h40, 8'h0F);
    chk({6'h00, bus_timeout_en, vrm_current}, 8'h00);
    wr(8'h40, 8'h00);
    rchk(8'h40, 8'h06);
    wr(8'h38, 8'h10);
    rchk(8'h38, 8'h40);
    @(posedge mclk) lim_fault <= 5'b11111;
    status2 <= 8'h04;
    @(posedge mclk) lim_fault <= 5'b00001;
    rchk(8'h41, 8'hF6);
    rchk(8'h41, 8'hC0);
    @(posedge mclk) lim_fault <= '0;
    status2 <= 8'h00;
    repeat (2) @(posedge mclk);
    rchk(8'h41, 8'h40);
    rchk(8'h41, 8'h00);
    @(posedge mclk) diode_fault <= 3'b001;
    repeat (2) @(posedge mclk);
    rchk(8'h25, 8'h80);
    rchk(8'h26, 8'h44);
    @(posedge mclk) temp_offset64 <= 1'b1;
    repeat (2) @(posedge mclk);
    rchk(8'h25, 8'h00);
    @(posedge mclk) diode_fault <= 3'b000;
    repeat (2) @(posedge mclk);
    rchk(8'h76, 8'h66);
    @(posedge mclk) live.vcore <= 8'hA1;
    repeat (2) @(posedge mclk);
    rchk(8'h21, 8'h11);
    rchk(8'h22, 8'h22);
    rchk(8'h25, 8'h33);
    rchk(8'h26, 8'h44);
    rchk(8'h27, 8'h55);
    repeat (2) @(posedge mclk);
    rchk(8'h21, 8'hA1);
    wrap_up();
  end
endmodule
`default_nettype wire
